// >>> bench/etc_timer_sva.sv
// port assertions for the eight-bit timer control
`timescale 1ns/1ps
`default_nettype none
module etc_timer_sva
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        first_port_data,
  input wire logic        first_output_pin,
  input wire logic        counter_a_output,
  input wire logic        external_irq_line
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_rdy_next;
    psel && !penable |=> pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("no answer after setup");

  property p_rdy_once;
    pready |=> !pready;
  endproperty
  a_rdy_once: assert property (p_rdy_once) else $error("pready longer than one cycle");

  property p_rdy_cause;
    pready |-> $past(psel) && !$past(penable);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("pready without setup");

  property p_err_align;
    psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_err_align: assert property (p_err_align) else $error("misaligned not refused");

  property p_err_data;
    pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refusal with data");

  property p_ok_ctrl;
    psel && !penable && (paddr == 8'h00 || paddr == 8'h10) |=> !pslverr;
  endproperty
  a_ok_ctrl: assert property (p_ok_ctrl) else $error("mapped address refused");

  property p_pad;
    pready |-> prdata[31:8] == 24'h000000;
  endproperty
  a_pad: assert property (p_pad) else $error("upper read bits set");

  property p_ext_pulse;
    external_irq_line |=> !external_irq_line;
  endproperty
  a_ext_pulse: assert property (p_ext_pulse) else $error("irq line held");

  property p_first_pin;
    first_output_pin |-> $past(counter_a_output) || $past(first_port_data);
  endproperty
  a_first_pin: assert property (p_first_pin) else $error("first pin source");
endmodule
bind etc_timer etc_timer_sva i_sva
(
  .clk               (clk),
  .rst_n             (rst_n),
  .psel              (psel),
  .penable           (penable),
  .paddr             (paddr),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .first_port_data   (first_port_data),
  .first_output_pin  (first_output_pin),
  .counter_a_output  (counter_a_output),
  .external_irq_line (external_irq_line)
);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking testbench for the eight-bit timer control
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk, rst_n, psel, penable, pwrite, stop_recovery;
  logic        port2_bit0_pin, port3_bit1_pin, first_port_data, second_port_data;
  logic [7:0]  paddr, q1, q2;
  logic [31:0] pwdata;
  logic        e, last_a;
  wire  [31:0] prdata;
  wire         pready, pslverr, first_output_pin, second_output_pin;
  wire         counter_a_output, counter_b_output, timeout_irq;
  wire         capture_irq, external_irq_line;
  int          n_errors, samples_checked, cyc, gap, span, ext_cnt, n;

  // ==========================================
  // device
  etc_timer i_dut
  (
    .clk               (clk),
    .rst_n             (rst_n),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .stop_recovery     (stop_recovery),
    .port2_bit0_pin    (port2_bit0_pin),
    .port3_bit1_pin    (port3_bit1_pin),
    .first_port_data   (first_port_data),
    .second_port_data  (second_port_data),
    .first_output_pin  (first_output_pin),
    .second_output_pin (second_output_pin),
    .counter_a_output  (counter_a_output),
    .counter_b_output  (counter_b_output),
    .timeout_irq       (timeout_irq),
    .capture_irq       (capture_irq),
    .external_irq_line (external_irq_line)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================
  // monitors and timeout
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    gap <= (counter_a_output !== last_a) ? 1 : gap + 1;
    if (counter_a_output !== last_a)
      span <= gap;
    last_a <= counter_a_output;
    if (external_irq_line === 1'b1)
      ext_cnt <= ext_cnt + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  // ==========================================
  // tasks
  task automatic conclude;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        n_errors++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic err);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, q1, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    begin
      apb(1'b0, a, 8'h00, q1, e);
      chk("prdata", exp, q1);
    end
  endtask

  task automatic pulse(input logic p3);
    begin
      if (p3)
        port3_bit1_pin <= 1'b1;
      else
        port2_bit0_pin <= 1'b1;
      ticks(12);
      port2_bit0_pin <= 1'b0;
      port3_bit1_pin <= 1'b0;
      ticks(12);
    end
  endtask

  // ==========================================
  // tests
  initial
  begin
    {rst_n, psel, penable, pwrite, stop_recovery, port2_bit0_pin} = 6'h00;
    {port3_bit1_pin, first_port_data, second_port_data} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ticks(4);
    rst_n <= 1'b1;
    ticks(1);
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    apb(1'b0, 8'h2c, 8'h00, q1, e);
    chk("unmapped_err", 8'h01, {7'h00, e});
    chk("unmapped_data", 8'h00, q1);
    apb(1'b1, 8'h01, 8'hff, q1, e);
    chk("misaligned_err", 8'h01, {7'h00, e});
    rd(8'h00, 8'h00);
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h03);
    wr(8'h18, 8'ha5);
    rd(8'h10, 8'h03);
    rd(8'h14, 8'h03);
    rd(8'h18, 8'ha5);
    // single pass, flag and masks, stop recovery
    wr(8'h00, 8'h20);
    wr(8'h00, 8'hc0);
    ticks(20);
    rd(8'h00, 8'h60);
    wr(8'h00, 8'h40);
    rd(8'h00, 8'h60);
    wr(8'h00, 8'h5f);
    wr(8'h04, 8'h4c);
    stop_recovery <= 1'b1;
    ticks(1);
    stop_recovery <= 1'b0;
    ticks(2);
    rd(8'h00, 8'h3e);
    rd(8'h04, 8'h00);
    chk("timeout_irq", 8'h01, {7'h00, timeout_irq});
    wr(8'h00, 8'h20);
    ticks(3);
    rd(8'h00, 8'h00);
    chk("timeout_irq", 8'h00, {7'h00, timeout_irq});
    // output pins in transmit mode
    first_port_data <= 1'b1;
    ticks(3);
    chk("first_pin", 8'h01, {7'h00, first_output_pin});
    wr(8'h04, 8'h01);
    ticks(2);
    chk("b_out", 8'h01, {7'h00, counter_b_output});
    wr(8'h04, 8'h09);
    ticks(2);
    chk("b_out", 8'h00, {7'h00, counter_b_output});
    wr(8'h04, 8'h4c);
    ticks(2);
    chk("second_pin", 8'h01, {7'h00, second_output_pin});
    wr(8'h04, 8'h0c);
    ticks(2);
    chk("second_pin", 8'h00, {7'h00, second_output_pin});
    // auto reload at every prescale code
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h00, {3'b100, c[1:0], 3'b001});
      ticks(120);
      chk("toggle_span", 8'd4 << c, span[7:0]);
    end
    wr(8'h00, 8'h01);
    ticks(10);
    rd(8'h00, 8'h21);
    apb(1'b0, 8'h28, 8'h00, q2, e);
    ticks(20);
    rd(8'h28, q2);
    wr(8'h00, 8'h20);
    rd(8'h00, 8'h00);
    // demodulation, rising edges
    wr(8'h04, 8'h90);
    wr(8'h00, 8'h84);
    pulse(1'b0);
    pulse(1'b0);
    chk("capture_irq", 8'h01, {7'h00, capture_irq});
    rd(8'h04, 8'h92);
    rd(8'h24, 8'h00);
    rd(8'h20, 8'h17);
    n = ext_cnt;
    pulse(1'b1);
    pulse(1'b1);
    chk("ext_quiet", 8'h00, 8'(ext_cnt - n));
    wr(8'h04, 8'hd2);
    ticks(3);
    rd(8'h04, 8'hd0);
    chk("capture_irq", 8'h00, {7'h00, capture_irq});
    n = ext_cnt;
    pulse(1'b1);
    pulse(1'b1);
    chk("ext_pulse", 8'h02, 8'(ext_cnt - n));
    ticks(300);
    rd(8'h00, 8'ha4);
    conclude();
  end
endmodule
`default_nettype wire

// >>> rtl/etc_defines.vh
// constants for the eight-bit timer control block
`ifndef ETC_DEFINES_VH
`define ETC_DEFINES_VH
// register indices, byte address is four times the index
`define ETC_IDX_CTRL      6'h00
`define ETC_IDX_SHARED    6'h01
`define ETC_IDX_A_LOW     6'h04
`define ETC_IDX_A_HIGH    6'h05
`define ETC_IDX_B_LOW     6'h06
`define ETC_IDX_RISE_CAP  6'h08
`define ETC_IDX_FALL_CAP  6'h09
`define ETC_IDX_COUNT     6'h0a
// control register fields
`define ETC_C_RUN         7
`define ETC_C_SINGLE      6
`define ETC_C_TIMEOUT     5
`define ETC_C_CLK_HI      4
`define ETC_C_CLK_LO      3
`define ETC_C_CAP_MASK    2
`define ETC_C_TO_MASK     1
`define ETC_C_OUT_SEL     0
// shared register fields
`define ETC_S_MODE        7
`define ETC_S_PIN_SEL     6
`define ETC_S_EDGE_HI     5
`define ETC_S_EDGE_LO     4
`define ETC_S_SUB_HI      3
`define ETC_S_SUB_LO      2
`define ETC_S_RISE        1
`define ETC_S_FALL        0
// encodings
`define ETC_EDGE_FALL     2'h0
`define ETC_EDGE_RISE     2'h1
`define ETC_SUB_FORCE_LO  2'h2
`define ETC_SUB_FORCE_HI  2'h3
`define ETC_FILT_NONE     2'h0
`define ETC_FILT_4        2'h1
`define ETC_FILT_8        2'h2
`define ETC_FILT_LEN_4    3'h3
`define ETC_FILT_LEN_8    3'h7
`define ETC_DIV2_MASK     3'h1
`define ETC_DIV4_MASK     3'h3
`define ETC_DIV8_MASK     3'h7
// values
`define ETC_BYTE_ZERO     8'h00
`define ETC_BYTE_ONE      8'h01
`define ETC_BYTE_FULL     8'hff
`define ETC_WORD_ZERO     32'h00000000
`define ETC_PAD_ZERO      24'h000000
`endif

// >>> rtl/etc_timer.v
// eight-bit timer control with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "etc_defines.vh"
module etc_timer
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        stop_recovery,
  input  wire        port2_bit0_pin,
  input  wire        port3_bit1_pin,
  input  wire        first_port_data,
  input  wire        second_port_data,
  output reg         first_output_pin,
  output reg         second_output_pin,
  output reg         counter_a_output,
  output reg         counter_b_output,
  output reg         timeout_irq,
  output reg         capture_irq,
  output reg         external_irq_line
);

  // ==========================================================
  // functions
  function [2:0] filt_len;
    input [1:0] code;
    begin
      case (code)
        `ETC_FILT_4: filt_len = `ETC_FILT_LEN_4;
        `ETC_FILT_8: filt_len = `ETC_FILT_LEN_8;
        default:     filt_len = 3'h0;
      endcase
    end
  endfunction

  function hit;
    input [5:0] idx;
    input [7:0] addr;
    begin
      hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
    end
  endfunction

  // ==========================================================
  // state
  reg        run, single, timeout, cap_mask, to_mask, out_sel;
  reg        mode, pin_sel, rise_flag, fall_flag, init_a, init_b;
  reg        stop_pend, started, filt, filt_prev;
  reg [1:0]  clk_sel, edge_sel, sub, p20_sync, p31_sync;
  reg [2:0]  div, clr_pend, filt_cnt;
  reg [7:0]  a_low, a_high, b_low, rise_cap, fall_cap, count;

  // ==========================================================
  // bus decode
  wire       setup   = psel && !penable;
  wire       wr      = psel && penable && pready && pwrite;
  wire       wr_ctrl = wr && hit(`ETC_IDX_CTRL, paddr);
  wire       wr_shr  = wr && hit(`ETC_IDX_SHARED, paddr);
  wire       mapped  = hit(`ETC_IDX_CTRL, paddr) || hit(`ETC_IDX_SHARED, paddr) ||
                       hit(`ETC_IDX_A_LOW, paddr) || hit(`ETC_IDX_A_HIGH, paddr) ||
                       hit(`ETC_IDX_B_LOW, paddr) || hit(`ETC_IDX_RISE_CAP, paddr) ||
                       hit(`ETC_IDX_FALL_CAP, paddr) || hit(`ETC_IDX_COUNT, paddr);
  wire [7:0] ctrl_rd = {run, single, timeout, clk_sel, cap_mask, to_mask, out_sel};
  wire [7:0] shr_rd  = {mode, pin_sel, edge_sel, sub,
                        mode ? rise_flag : init_a, mode ? fall_flag : init_b};

  // ==========================================================
  // prescaler, free running so the first tick lands anywhere
  reg tick;
  always @*
  begin
    case (clk_sel)
      2'h0:    tick = 1'b1;
      2'h1:    tick = (div & `ETC_DIV2_MASK) == `ETC_DIV2_MASK;
      2'h2:    tick = (div & `ETC_DIV4_MASK) == `ETC_DIV4_MASK;
      default: tick = (div & `ETC_DIV8_MASK) == `ETC_DIV8_MASK;
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  // ==========================================================
  // demodulation input: sync, glitch filter, edge detect
  wire       dem_in   = pin_sel ? p31_sync[1] : p20_sync[1];
  wire [2:0] flen     = filt_len(sub);
  wire       rise_ev  = filt && !filt_prev;
  wire       fall_ev  = !filt && filt_prev;
  wire       rise_q   = rise_ev && (edge_sel != `ETC_EDGE_FALL);
  wire       fall_q   = fall_ev && (edge_sel != `ETC_EDGE_RISE);
  wire       dem_edge = mode && run && (rise_q || fall_q);
  wire       capture  = dem_edge && started;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      p20_sync  <= 2'h0;
      p31_sync  <= 2'h0;
      filt      <= 1'b0;
      filt_prev <= 1'b0;
      filt_cnt  <= 3'h0;
    end
    else
    begin
      p20_sync  <= {p20_sync[0], port2_bit0_pin};
      p31_sync  <= {p31_sync[0], port3_bit1_pin};
      filt_prev <= filt;
      if (dem_in == filt)
        filt_cnt <= 3'h0;
      else if (filt_cnt >= flen)
      begin
        filt     <= dem_in;
        filt_cnt <= 3'h0;
      end
      else
        filt_cnt <= filt_cnt + 3'h1;
    end
  end

  // ==========================================================
  // terminal count and timeout detection
  wire tx_term = !mode && run && tick && (count == `ETC_BYTE_ZERO);
  wire dm_zero = mode && run && started && tick && !capture &&
                 (count == `ETC_BYTE_ONE);
  wire to_set  = tx_term || dm_zero;

  // ==========================================================
  // counter core
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run              <= 1'b0;
      stop_pend        <= 1'b0;
      started          <= 1'b0;
      count            <= `ETC_BYTE_ZERO;
      counter_a_output <= 1'b0;
      rise_cap         <= `ETC_BYTE_ZERO;
      fall_cap         <= `ETC_BYTE_ZERO;
    end
    else if (stop_recovery)
    begin
      run       <= 1'b0;
      stop_pend <= 1'b0;
      started   <= 1'b0;
    end
    else if (wr_ctrl && pwdata[`ETC_C_RUN] && !run)
    begin
      run              <= 1'b1;
      stop_pend        <= 1'b0;
      started          <= 1'b0;
      count            <= mode ? `ETC_BYTE_FULL : a_low;
      counter_a_output <= init_a;
    end
    else
    begin
      if (wr_ctrl && !pwdata[`ETC_C_RUN])
        stop_pend <= 1'b1;
      else if (tick)
        stop_pend <= 1'b0;
      if (tick && stop_pend)
        run <= 1'b0;
      if (capture)
      begin
        if (rise_q)
          rise_cap <= ~count;
        else
          fall_cap <= ~count;
        count <= `ETC_BYTE_FULL;
      end
      else if (dem_edge)
      begin
        started <= 1'b1;
        count   <= `ETC_BYTE_FULL;
      end
      else if (mode && run && started && tick)
        count <= count - `ETC_BYTE_ONE;
      else if (tx_term)
      begin
        counter_a_output <= !counter_a_output;
        count            <= counter_a_output ? a_low : a_high;
        if (single)
          run <= 1'b0;
      end
      else if (!mode && run && tick)
        count <= count - `ETC_BYTE_ONE;
    end
  end

  // ==========================================================
  // configuration and flags
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      single    <= 1'b0;
      out_sel   <= 1'b0;
      mode      <= 1'b0;
      pin_sel   <= 1'b0;
      edge_sel  <= 2'h0;
      sub       <= 2'h0;
      init_a    <= 1'b0;
      init_b    <= 1'b0;
      timeout   <= 1'b0;
      clk_sel   <= 2'h0;
      cap_mask  <= 1'b0;
      to_mask   <= 1'b0;
      rise_flag <= 1'b0;
      fall_flag <= 1'b0;
      clr_pend  <= 3'h0;
      a_low     <= `ETC_BYTE_ZERO;
      a_high    <= `ETC_BYTE_ZERO;
      b_low     <= `ETC_BYTE_ZERO;
    end
    else
    begin
      if (stop_recovery)
      begin
        single   <= 1'b0;
        out_sel  <= 1'b0;
        mode     <= 1'b0;
        pin_sel  <= 1'b0;
        edge_sel <= 2'h0;
        sub      <= 2'h0;
        init_a   <= 1'b0;
        init_b   <= 1'b0;
      end
      else
      begin
        if (wr_ctrl)
        begin
          single   <= pwdata[`ETC_C_SINGLE];
          clk_sel  <= pwdata[`ETC_C_CLK_HI:`ETC_C_CLK_LO];
          cap_mask <= pwdata[`ETC_C_CAP_MASK];
          to_mask  <= pwdata[`ETC_C_TO_MASK];
          out_sel  <= pwdata[`ETC_C_OUT_SEL];
        end
        if (wr_shr)
        begin
          mode     <= pwdata[`ETC_S_MODE];
          pin_sel  <= pwdata[`ETC_S_PIN_SEL];
          edge_sel <= pwdata[`ETC_S_EDGE_HI:`ETC_S_EDGE_LO];
          sub      <= pwdata[`ETC_S_SUB_HI:`ETC_S_SUB_LO];
          if (!mode)
          begin
            init_a <= pwdata[`ETC_S_RISE];
            init_b <= pwdata[`ETC_S_FALL];
          end
        end
        if (wr && hit(`ETC_IDX_A_LOW, paddr))
          a_low <= pwdata[7:0];
        if (wr && hit(`ETC_IDX_A_HIGH, paddr))
          a_high <= pwdata[7:0];
        if (wr && hit(`ETC_IDX_B_LOW, paddr))
          b_low <= pwdata[7:0];
      end
      // clears wait for the next tick; a set in that tick wins
      if (tick)
      begin
        timeout   <= to_set || (timeout && !clr_pend[2]);
        rise_flag <= (capture && rise_q) || (rise_flag && !clr_pend[1]);
        fall_flag <= (capture && !rise_q) || (fall_flag && !clr_pend[0]);
        clr_pend  <= {wr_ctrl && pwdata[`ETC_C_TIMEOUT],
                      wr_shr && mode && pwdata[`ETC_S_RISE],
                      wr_shr && mode && pwdata[`ETC_S_FALL]};
      end
      else
      begin
        if (capture && rise_q)
          rise_flag <= 1'b1;
        if (capture && !rise_q)
          fall_flag <= 1'b1;
        clr_pend <= clr_pend | {wr_ctrl && pwdata[`ETC_C_TIMEOUT],
                                wr_shr && mode && pwdata[`ETC_S_RISE],
                                wr_shr && mode && pwdata[`ETC_S_FALL]};
      end
    end
  end

  // ==========================================================
  // pins and interrupt request lines
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_output_pin  <= 1'b0;
      second_output_pin <= 1'b0;
      counter_b_output  <= 1'b0;
      timeout_irq       <= 1'b0;
      capture_irq       <= 1'b0;
      external_irq_line <= 1'b0;
    end
    else
    begin
      first_output_pin  <= out_sel ? counter_a_output : first_port_data;
      second_output_pin <= (!mode && pin_sel) ? (counter_a_output | counter_b_output)
                                              : second_port_data;
      if (sub == `ETC_SUB_FORCE_LO && !mode)
        counter_b_output <= 1'b0;
      else if (sub == `ETC_SUB_FORCE_HI && !mode)
        counter_b_output <= 1'b1;
      else
        counter_b_output <= init_b;
      timeout_irq       <= timeout && to_mask;
      capture_irq       <= (rise_flag || fall_flag) && mode && cap_mask;
      external_irq_line <= capture && pin_sel;
    end
  end

  // ==========================================================
  // apb slave, no wait states
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `ETC_WORD_ZERO;
    end
    else if (setup)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      if (pwrite || !mapped)
        prdata <= `ETC_WORD_ZERO;
      else if (hit(`ETC_IDX_CTRL, paddr))
        prdata <= {`ETC_PAD_ZERO, ctrl_rd};
      else if (hit(`ETC_IDX_SHARED, paddr))
        prdata <= {`ETC_PAD_ZERO, shr_rd};
      else if (hit(`ETC_IDX_A_LOW, paddr))
        prdata <= {`ETC_PAD_ZERO, a_low};
      else if (hit(`ETC_IDX_A_HIGH, paddr))
        prdata <= {`ETC_PAD_ZERO, a_high};
      else if (hit(`ETC_IDX_B_LOW, paddr))
        prdata <= {`ETC_PAD_ZERO, b_low};
      else if (hit(`ETC_IDX_RISE_CAP, paddr))
        prdata <= {`ETC_PAD_ZERO, rise_cap};
      else if (hit(`ETC_IDX_FALL_CAP, paddr))
        prdata <= {`ETC_PAD_ZERO, fall_cap};
      else
        prdata <= {`ETC_PAD_ZERO, count};
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire
